// ---- ptdc_timer.sv ----
// periodic tick down counter with avalon-mm registers
`timescale 1ns/100ps
`default_nettype none
`include "ptdc_cfg.svh"
module ptdc_timer
  import ptdc_pkg::*;
#(
  parameter int CNT_W = `PTDC_CNT_W
)
(
  // clock and reset
  input  wire logic               mclk_i,
  input  wire logic               rst_i,
  // avalon-mm slave
  input  wire logic [`PTDC_ADDR_W-1:0] avs_address_i,
  input  wire logic               avs_read_i,
  input  wire logic               avs_write_i,
  input  wire logic [31:0]        avs_writedata_i,
  input  wire logic [3:0]         avs_byteenable_i,
  output logic [31:0]             avs_readdata_o,
  output logic                    avs_waitrequest_o,
  // interrupt controller side
  input  wire logic               irq_ack_i,
  output logic                    irq_o
);
  // readback packs the count into the low 24 bits of the word
  if (CNT_W != `PTDC_CNT_W)
  begin : g_width_check
    $error("counter width must be 24");
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [CNT_W-1:0]   reload_reg;
  logic [CNT_W-1:0]   count_reg;
  logic               en_reg;
  logic               ie_reg;
  logic               wrap_reg;
  logic               roll_seen_reg;
  logic [31:0]        rdata_reg;
  ptdc_bus_state_type bus_reg;
  logic               acc;
  logic               wr_go;
  logic               rollover;

  // one wait cycle, answer on the second edge
  assign acc   = (avs_read_i | avs_write_i) && bus_reg == PTDC_BUS_IDLE;
  assign wr_go = avs_write_i && bus_reg == PTDC_BUS_ACK;
  assign avs_waitrequest_o = (avs_read_i | avs_write_i)
                             && bus_reg != PTDC_BUS_ACK;
  assign avs_readdata_o = rdata_reg;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      bus_reg <= PTDC_BUS_IDLE;
    else
    begin
      case (bus_reg)
        PTDC_BUS_IDLE: bus_reg <= acc ? PTDC_BUS_ACK : PTDC_BUS_IDLE;
        PTDC_BUS_ACK:  bus_reg <= PTDC_BUS_IDLE;
        default:       bus_reg <= PTDC_BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      en_reg <= 1'b0;
      ie_reg <= 1'b0;
    end
    else if (wr_go && avs_address_i == `PTDC_OFF_CTRL
             && avs_byteenable_i[0])
    begin
      en_reg <= avs_writedata_i[`PTDC_CTRL_EN_BIT];
      ie_reg <= avs_writedata_i[`PTDC_CTRL_IE_BIT];
    end
  end

  // stored value is period minus one, so 1..2^24 all fit
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      reload_reg <= `PTDC_RELOAD_RST;
    else if (wr_go && avs_address_i == `PTDC_OFF_RELOAD
             && avs_byteenable_i[2:0] == 3'h7)
      reload_reg <= avs_writedata_i[CNT_W-1:0];
  end

  // ----------------------------------------------------------------
  // down counter
  // ----------------------------------------------------------------
  // zero after clear reloads on first enabled clock
  assign rollover = en_reg && count_reg == '0 && !wrap_reg;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      count_reg <= '0;
      wrap_reg  <= 1'b1;
    end
    else if (wr_go && avs_address_i == `PTDC_OFF_CURRENT)
    begin
      count_reg <= '0;
      wrap_reg  <= 1'b1;
    end
    // resumes from held value; stopped when disabled
    else if (en_reg)
    begin
      // reload at zero; period read only here
      if (count_reg == '0)
        count_reg <= reload_reg;
      else
        count_reg <= count_reg - 1'b1;
      wrap_reg <= 1'b0;
    end
  end

  // rollover while enabled flags a tick
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      roll_seen_reg <= 1'b0;
    else if (rollover)
      roll_seen_reg <= 1'b1;
    // cleared at the capture edge, so a tick cannot slip between
    else if (acc && avs_read_i && avs_address_i == `PTDC_OFF_STATUS)
      roll_seen_reg <= 1'b0;
  end

  // count can exceed the stored period minus one after it is lowered, until the next reload
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      rdata_reg <= '0;
    // captured at the accept edge so data stand when wait drops
    else if (acc && avs_read_i)
    begin
      case (avs_address_i)
        `PTDC_OFF_CTRL:    rdata_reg <= {30'h0, ie_reg, en_reg};
        `PTDC_OFF_RELOAD:  rdata_reg <= {8'h0, reload_reg};
        `PTDC_OFF_CURRENT: rdata_reg <= {8'h0, count_reg};
        `PTDC_OFF_STATUS:  rdata_reg <= {31'h0, roll_seen_reg};
        default:           rdata_reg <= `PTDC_UNMAPPED_VAL;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // interrupt request
  // ----------------------------------------------------------------
  // gated by irq enable; cleared by handler entry
  ptdc_irq_pend u_pend (
    .mclk_i   (mclk_i),
    .rst_i    (rst_i),
    .set_i    (rollover),
    .ack_i    (irq_ack_i),
    .int_en_i (ie_reg),
    .irq_o    (irq_o)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_clear_on_write;
    @(posedge mclk_i) disable iff (rst_i)
    wr_go && avs_address_i == `PTDC_OFF_CURRENT |=> count_reg == '0;
  endproperty
  a_clear_on_write: assert property (p_clear_on_write)
    else $error("current count not cleared by write");

  property p_reload_after_clear;
    @(posedge mclk_i) disable iff (rst_i)
    en_reg && count_reg == '0 && !(wr_go && avs_address_i ==
      `PTDC_OFF_CURRENT) |=> count_reg == $past(reload_reg);
  endproperty
  a_reload_after_clear: assert property (p_reload_after_clear)
    else $error("period not loaded at zero");

  property p_count_down;
    @(posedge mclk_i) disable iff (rst_i)
    en_reg && count_reg != '0 && !wr_go |=> count_reg ==
      $past(count_reg) - 1'b1;
  endproperty
  a_count_down: assert property (p_count_down)
    else $error("counter did not decrement");

  property p_hold_when_off;
    @(posedge mclk_i) disable iff (rst_i)
    !en_reg && !wr_go |=> $stable(count_reg);
  endproperty
  a_hold_when_off: assert property (p_hold_when_off)
    else $error("counter moved while disabled");

  property p_no_roll_off;
    @(posedge mclk_i) disable iff (rst_i)
    !en_reg |=> !$rose(u_pend.pend_reg);
  endproperty
  a_no_roll_off: assert property (p_no_roll_off)
    else $error("rollover while disabled");

  property p_irq_raise;
    @(posedge mclk_i) disable iff (rst_i)
    rollover && ie_reg ##1 ie_reg |-> irq_o;
  endproperty
  a_irq_raise: assert property (p_irq_raise)
    else $error("rollover did not raise interrupt");

  property p_irq_gate;
    @(posedge mclk_i) disable iff (rst_i)
    !ie_reg |-> !irq_o;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt passed while disabled");

  property p_irq_ack;
    @(posedge mclk_i) disable iff (rst_i)
    irq_ack_i && !rollover |=> !irq_o;
  endproperty
  a_irq_ack: assert property (p_irq_ack)
    else $error("interrupt not cleared on handler entry");

  // a nonzero count may only fall, hold or be cleared
  property p_range;
    @(posedge mclk_i) disable iff (rst_i)
    count_reg != '0 |=> count_reg <= $past(count_reg);
  endproperty
  a_range: assert property (p_range)
    else $error("counter moved upward");

  property p_rdata_count;
    @(posedge mclk_i) disable iff (rst_i)
    acc && avs_read_i && avs_address_i == `PTDC_OFF_CURRENT
      |=> avs_readdata_o == {8'h0, $past(count_reg)};
  endproperty
  a_rdata_count: assert property (p_rdata_count)
    else $error("current count read back wrong");

  property p_reload_write;
    @(posedge mclk_i) disable iff (rst_i)
    wr_go && avs_address_i == `PTDC_OFF_RELOAD
      && avs_byteenable_i[2:0] == 3'h7
      |=> {8'h0, reload_reg} == ($past(avs_writedata_i) & 32'h00ff_ffff);
  endproperty
  a_reload_write: assert property (p_reload_write)
    else $error("period not stored");

  property p_en_write;
    @(posedge mclk_i) disable iff (rst_i)
    wr_go && avs_address_i == `PTDC_OFF_CTRL && avs_byteenable_i[0]
      |=> {30'h0, ie_reg, en_reg} == ($past(avs_writedata_i) & 32'h3);
  endproperty
  a_en_write: assert property (p_en_write)
    else $error("control bits not stored");

  property p_seen_set;
    @(posedge mclk_i) disable iff (rst_i)
    rollover |=> roll_seen_reg;
  endproperty
  a_seen_set: assert property (p_seen_set)
    else $error("rollover not recorded");

  // only handler entry or the enable may drop a pending request
  property p_irq_hold;
    @(posedge mclk_i) disable iff (rst_i)
    irq_o && !irq_ack_i && !(wr_go && avs_address_i == `PTDC_OFF_CTRL)
      |=> irq_o;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt dropped without handler entry");

  property p_reset_state;
    @(posedge mclk_i) $fell(rst_i) |-> !en_reg && !ie_reg && !irq_o;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("reset state wrong");

  c_rollover: cover property (@(posedge mclk_i) rollover && ie_reg);
  c_clear: cover property (@(posedge mclk_i)
    wr_go && avs_address_i == `PTDC_OFF_CURRENT);
  c_ack: cover property (@(posedge mclk_i) irq_o ##1 irq_ack_i);
  c_first_load: cover property (@(posedge mclk_i) en_reg && wrap_reg);
  c_gated: cover property (@(posedge mclk_i) rollover && !ie_reg);
endmodule : ptdc_timer
`default_nettype wire

// ---- ptdc_cfg.svh ----
// constants for the periodic tick down counter
`ifndef PTDC_CFG_SVH
`define PTDC_CFG_SVH
`define PTDC_CNT_W        24
`define PTDC_ADDR_W       4
`define PTDC_OFF_CTRL     4'h0
`define PTDC_OFF_RELOAD   4'h4
`define PTDC_OFF_CURRENT  4'h8
`define PTDC_OFF_STATUS   4'hc
`define PTDC_CTRL_EN_BIT  0
`define PTDC_CTRL_IE_BIT  1
`define PTDC_RELOAD_RST   24'hff_ffff
`define PTDC_UNMAPPED_VAL 32'hdead_0bad
`endif

// ---- ptdc_pkg.sv ----
// types for the periodic tick down counter
package ptdc_pkg;
  typedef enum logic [1:0] {
    PTDC_BUS_IDLE = 2'b00,
    PTDC_BUS_ACK  = 2'b01
  } ptdc_bus_state_type;
endpackage : ptdc_pkg

// ---- ptdc_irq_pend.sv ----
// pending flag for the rollover interrupt, cleared on handler entry
`timescale 1ns/100ps
`default_nettype none
module ptdc_irq_pend
  import ptdc_pkg::*;
(
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_i,
  // events
  input  wire logic set_i,
  input  wire logic ack_i,
  input  wire logic int_en_i,
  // request
  output logic      irq_o
);
  logic pend_reg;

  // set wins over a same-cycle handler acknowledge
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      pend_reg <= 1'b0;
    else if (set_i)
      pend_reg <= 1'b1;
    else if (ack_i)
      pend_reg <= 1'b0;
  end

  assign irq_o = pend_reg & int_en_i;
endmodule : ptdc_irq_pend
`default_nettype wire

// ---- ptdc_irq_ctrl_model.sv ----
// interrupt controller model: acknowledges the tick request
`timescale 1ns/100ps
`default_nettype none
module ptdc_irq_ctrl_model
(
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  // request side
  input  wire logic       irq_i,
  input  wire logic [3:0] lat_i,
  output logic            ack_o
);
  logic [3:0] wait_reg;
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || !irq_i || ack_o)
    begin
      wait_reg <= 4'h0;
      ack_o    <= 1'b0;
    end
    else if (wait_reg == lat_i)
      ack_o <= 1'b1;
    else
      wait_reg <= wait_reg + 4'h1;
  end
endmodule : ptdc_irq_ctrl_model
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the tick down counter
`timescale 1ns/100ps
`default_nettype none
`include "ptdc_cfg.svh"
`define CHK(a,b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [3:0]  avs_address_i = 4'h0;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        irq_ack_i;
  logic        irq_o;
  logic        irq_q = 1'b0;
  logic [3:0]  lat = 4'h1;
  logic [31:0] q, v;
  int          n_mismatch = 0, total_checks = 0;
  int          cyc = 0, rises = 0, last = 0, ival = 0;

  always #4 mclk_i = ~mclk_i;

  ptdc_timer DUT (.mclk_i(mclk_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .irq_ack_i(irq_ack_i),
    .irq_o(irq_o));
  ptdc_irq_ctrl_model ctrl_model (.mclk_i(mclk_i), .rst_i(rst_i),
    .irq_i(irq_o), .lat_i(lat), .ack_o(irq_ack_i));

  // timing of request edges; timeout cuts a hang
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    irq_q <= irq_o;
    if (irq_o === 1'b1 && irq_q === 1'b0)
    begin
      rises <= rises + 1;
      ival <= cyc - last;
      last <= cyc;
    end
    if (cyc == 20000)
    begin
      n_mismatch++;
      end_sim();
    end
  end

  // --------------------------------------------------------------
  // bus access and measurement
  // --------------------------------------------------------------
  // request held until waitrequest is seen low at a rising edge
  task automatic acc(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do
    begin
      @(posedge mclk_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : acc

  // skips two intervals that may straddle a period change
  task automatic measure(input int exp);
    int r = rises;
    while (rises < r + 3)
    begin
      @(negedge mclk_i);
    end
    `CHK(ival, exp)
  endtask : measure

  task automatic idle(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : idle

  task automatic end_sim();
    $display("mismatches %0d checks %0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial
  begin
    idle(8);
    rst_i <= 1'b0;
    acc(1'b0, `PTDC_OFF_CTRL, 32'h0);
    `CHK(q, 32'h0)
    acc(1'b0, `PTDC_OFF_RELOAD, 32'h0);
    `CHK(q, 32'h00ff_ffff)
    acc(1'b0, `PTDC_OFF_CURRENT, 32'h0);
    `CHK(q, 32'h0)
    acc(1'b0, 4'h1, 32'h0);
    `CHK(q, `PTDC_UNMAPPED_VAL)
    acc(1'b1, `PTDC_OFF_RELOAD, 32'h0000_0004);
    acc(1'b0, `PTDC_OFF_RELOAD, 32'h0);
    `CHK(q, 32'h0000_0004)
    acc(1'b1, `PTDC_OFF_CTRL, 32'h0000_0003);
    measure(5);
    measure(5);
    repeat (4)
    begin
      acc(1'b0, `PTDC_OFF_CURRENT, 32'h0);
      `CHK(q < 32'h5, 1'b1)
    end
    acc(1'b1, `PTDC_OFF_RELOAD, 32'h0000_0009);
    measure(10);
    lat <= 4'h6;
    measure(10);
    acc(1'b1, `PTDC_OFF_CTRL, 32'h0000_0001);
    idle(2);
    v = rises;
    idle(30);
    `CHK(rises, v)
    acc(1'b0, `PTDC_OFF_STATUS, 32'h0);
    `CHK(q[0], 1'b1)
    acc(1'b1, `PTDC_OFF_CTRL, 32'h0000_0002);
    acc(1'b0, `PTDC_OFF_CURRENT, 32'h0);
    v = q;
    acc(1'b0, `PTDC_OFF_STATUS, 32'h0);
    idle(30);
    acc(1'b0, `PTDC_OFF_CURRENT, 32'h0);
    `CHK(q, v)
    acc(1'b0, `PTDC_OFF_STATUS, 32'h0);
    `CHK(q[0], 1'b0)
    acc(1'b1, `PTDC_OFF_CURRENT, 32'h00a5_a5a5);
    acc(1'b0, `PTDC_OFF_CURRENT, 32'h0);
    `CHK(q, 32'h0)
    acc(1'b1, `PTDC_OFF_CTRL, 32'h0000_0003);
    measure(10);
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
